// file: rtl/lcdcrs_ctrl.v
// reset, standby and command decode logic of the lcd controller
`timescale 1ns/1ps
`include "lcdcrs_map.vh"
module lcdcrs_ctrl #(
   parameter SINGLE_CHIP = 1'b0
) (
   input  wire       CLK,
   input  wire       SYS_RST,
   input  wire       CS_N,
   input  wire       STRAP_ADDR_BIT0,
   input  wire       STRAP_ADDR_BIT1,
   input  wire       PAR_SER_PIN,
   input  wire       ADDR_MATCH_ENABLE_STRAP,
   input  wire       CMD_VALID,
   input  wire [7:0] CMD_BYTE,
   input  wire       DATA_VALID,
   input  wire       BYTE_PART,
   output reg        READY_N_OUT,
   output reg        READY_N_OE,
   output reg        STANDBY,
   output reg        CLOCK_RUN,
   output reg  [1:0] DRIVE_LEVEL,
   output reg        DISPLAY_ON,
   output reg        MEM_HOLD,
   output reg  [2:0] PROC_MODE,
   output reg  [1:0] POINTER_STEP_FIELD,
   output reg  [6:0] POINTER,
   output reg  [2:0] MULTIPLEX_FIELD,
   output reg  [2:0] FRAME_DIV_FIELD,
   output reg        FRAME_TICK,
   output reg        PARALLEL_MODE,
   output reg        ADDR_MATCH_ENABLE,
   output reg  [1:0] CHIP_ADDR_CMP,
   output reg        CHIP_SELECTED,
   output reg        XFER_PART,
   output reg        BIT_CLEAR_CMD,
   output reg        BIT_SET_CMD,
   output reg  [4:0] BIT_OPERAND,
   output reg        CURSOR_CLEAR_CMD,
   output reg        CURSOR_WRITE_CMD
);
   // ************************************************************
   // pin synchronisers
   // ************************************************************
   reg  [2:0] sync_cs;
   reg  [2:0] sync_a0;
   reg  [2:0] sync_a1;
   reg  [2:0] sync_ps;
   reg  [2:0] sync_ae;
   reg        cs_n;
   reg        addr0;
   reg        addr1;
   reg        ps;
   reg        ae;
   reg        rst_q;
   always @(posedge CLK) begin
      sync_cs <= {sync_cs[1:0], CS_N};
      sync_a0 <= {sync_a0[1:0], STRAP_ADDR_BIT0};
      sync_a1 <= {sync_a1[1:0], STRAP_ADDR_BIT1};
      sync_ps <= {sync_ps[1:0], PAR_SER_PIN};
      sync_ae <= {sync_ae[1:0], ADDR_MATCH_ENABLE_STRAP};
      if (sync_cs[2] == sync_cs[1]) cs_n  <= sync_cs[2];
      if (sync_a0[2] == sync_a0[1]) addr0 <= sync_a0[2];
      if (sync_a1[2] == sync_a1[1]) addr1 <= sync_a1[2];
      if (sync_ps[2] == sync_ps[1]) ps    <= sync_ps[2];
      if (sync_ae[2] == sync_ae[1]) ae    <= sync_ae[2];
      rst_q <= SYS_RST;
   end
   // ************************************************************
   // command decode
   // ************************************************************
   function in_range;
      input [7:0] code;
      input [7:0] lo;
      input [7:0] hi;
      begin
         in_range = (code >= lo) && (code <= hi);
      end
   endfunction
   wire [7:0] c = CMD_BYTE;
   wire take = CMD_VALID && !SYS_RST;
   wire stop_cmd         = take && (c == `LCDCRS_CMD_STOP);
   wire display_off_cmd  = take && (c == `LCDCRS_CMD_DISPLAY_OFF_CMD);
   wire display_on_cmd   = take && (c == `LCDCRS_CMD_DISPLAY_ON_CMD);
   wire frame_rate_cmd   = take && in_range(c, `LCDCRS_CMD_FRAME_LO, `LCDCRS_CMD_FRAME_HI);
   wire multiplex_cmd    = take && in_range(c, `LCDCRS_CMD_MUX_LO, `LCDCRS_CMD_MUX_HI);
   wire bit_clear_cmd    = take && in_range(c, `LCDCRS_CMD_BCLR_LO, `LCDCRS_CMD_BCLR_HI);
   wire bit_set_cmd      = take && in_range(c, `LCDCRS_CMD_BIT_SET_CMD_LO, `LCDCRS_CMD_BIT_SET_CMD_HI);
   wire read_mode_cmd    = take && in_range(c, `LCDCRS_CMD_READ_LO, `LCDCRS_CMD_READ_HI);
   wire write_mode_cmd   = take && in_range(c, `LCDCRS_CMD_WRITE_LO, `LCDCRS_CMD_WRITE_HI);
   wire or_mode_cmd      = take && in_range(c, `LCDCRS_CMD_OR_LO, `LCDCRS_CMD_OR_HI);
   wire and_mode_cmd     = take && in_range(c, `LCDCRS_CMD_AND_LO, `LCDCRS_CMD_AND_HI);
   wire char_left_cmd    = take && (c == `LCDCRS_CMD_CHAR_LEFT);
   wire char_right_cmd   = take && (c == `LCDCRS_CMD_CHAR_RIGHT);
   wire cursor_clear_cmd = take && (c == `LCDCRS_CMD_CUR_CLR);
   wire cursor_write_cmd = take && (c == `LCDCRS_CMD_CUR_WR);
   wire pointer_load_cmd = take && (in_range(c, `LCDCRS_CMD_PTR_A_LO, `LCDCRS_CMD_PTR_A_HI) ||
                                    in_range(c, `LCDCRS_CMD_PTR_B_LO, `LCDCRS_CMD_PTR_B_HI));
   wire mode_cmd = read_mode_cmd || write_mode_cmd || or_mode_cmd || and_mode_cmd;
   wire any_byte = take || (DATA_VALID && !SYS_RST);
   // ************************************************************
   // standby and reset
   // ************************************************************
   wire rst_fall = rst_q && !SYS_RST;
   wire frame_tick;
   always @(posedge CLK) begin
      if (SYS_RST) begin
         // standby kept while reset high
         MEM_HOLD    <= STANDBY;
         CLOCK_RUN   <= 1'b0;
         DRIVE_LEVEL <= `LCDCRS_DRIVE_MID_BIAS;
         DISPLAY_ON  <= 1'b0;
      end else if (rst_fall) begin
         STANDBY     <= 1'b0;
         CLOCK_RUN   <= 1'b1;
         DRIVE_LEVEL <= `LCDCRS_DRIVE_OFF;
         MEM_HOLD    <= MEM_HOLD;
      end else if (stop_cmd) begin
         STANDBY     <= 1'b1;
         CLOCK_RUN   <= 1'b0;
         MEM_HOLD    <= 1'b1;
      end else if (STANDBY && any_byte) begin
         STANDBY     <= 1'b0;
         CLOCK_RUN   <= 1'b1;
      end else begin
         if (display_off_cmd) begin
            DISPLAY_ON  <= 1'b0;
            DRIVE_LEVEL <= `LCDCRS_DRIVE_OFF;
         end else if (display_on_cmd) begin
            DISPLAY_ON  <= 1'b1;
            DRIVE_LEVEL <= `LCDCRS_DRIVE_ON;
         end
      end
   end
   // ************************************************************
   // modes and pointer
   // ************************************************************
   always @(posedge CLK) begin
      BIT_CLEAR_CMD    <= bit_clear_cmd;
      BIT_SET_CMD      <= bit_set_cmd;
      BIT_OPERAND      <= c[4:0];
      CURSOR_CLEAR_CMD <= cursor_clear_cmd;
      CURSOR_WRITE_CMD <= cursor_write_cmd;
      if (SYS_RST) begin
         PROC_MODE          <= `LCDCRS_MODE_WRITE;
         POINTER_STEP_FIELD <= `LCDCRS_RST_STEP;
         POINTER            <= `LCDCRS_RST_PTR;
         MULTIPLEX_FIELD    <= `LCDCRS_RST_MUX;
         FRAME_DIV_FIELD    <= `LCDCRS_RST_FRAME;
         XFER_PART          <= 1'b0;
         BIT_CLEAR_CMD      <= 1'b0;
         BIT_SET_CMD        <= 1'b0;
         CURSOR_CLEAR_CMD   <= 1'b0;
         CURSOR_WRITE_CMD   <= 1'b0;
      end else begin
         XFER_PART <= BYTE_PART;
         if (stop_cmd) begin
            PROC_MODE          <= `LCDCRS_MODE_WRITE;
            POINTER_STEP_FIELD <= `LCDCRS_RST_STEP;
         end
         if (frame_rate_cmd) FRAME_DIV_FIELD <= c[2:0];
         if (multiplex_cmd) MULTIPLEX_FIELD <= c[2:0];
         if (pointer_load_cmd) POINTER <= c[6:0];
         if (mode_cmd) POINTER_STEP_FIELD <= c[1:0];
         if (read_mode_cmd) PROC_MODE <= `LCDCRS_MODE_READ;
         if (write_mode_cmd) PROC_MODE <= `LCDCRS_MODE_WRITE;
         if (or_mode_cmd) PROC_MODE <= `LCDCRS_MODE_OR;
         if (and_mode_cmd) PROC_MODE <= `LCDCRS_MODE_AND;
         if (char_left_cmd) PROC_MODE <= `LCDCRS_MODE_CHAR_LEFT;
         if (char_right_cmd) PROC_MODE <= `LCDCRS_MODE_CHAR_RIGHT;
         // other codes fall through untouched
      end
   end
   // ************************************************************
   // straps, address and ready pin
   // ************************************************************
   wire addr_zero = SINGLE_CHIP || ({addr1, addr0} == `LCDCRS_RST_ADDR);
   always @(posedge CLK) begin
      if (SYS_RST) begin
         CHIP_ADDR_CMP <= `LCDCRS_RST_ADDR;
         CHIP_SELECTED <= 1'b0;
         READY_N_OUT   <= 1'b0;
         READY_N_OE    <= addr_zero && !cs_n;
      end else begin
         if (rst_fall) begin
            PARALLEL_MODE     <= ps;
            ADDR_MATCH_ENABLE <= ae;
            CHIP_SELECTED     <= addr_zero;
         end
         READY_N_OUT <= STANDBY || stop_cmd;
         READY_N_OE  <= CHIP_SELECTED && !cs_n;
      end
   end
   // ************************************************************
   // frame divider
   // ************************************************************
   lcdcrs_frame_div #(
      .WIDTH (`LCDCRS_DIV_WIDTH)
   ) u_div (
      .clk             (CLK),
      .sys_rst         (SYS_RST),
      .run             (CLOCK_RUN),
      .frame_div_field (FRAME_DIV_FIELD),
      .frame_tick      (frame_tick)
   );
   always @(posedge CLK) begin
      if (SYS_RST) FRAME_TICK <= 1'b0;
      else FRAME_TICK <= frame_tick;
   end
   initial begin
      STANDBY = 1'b0;
      MEM_HOLD = 1'b0;
      PARALLEL_MODE = 1'b0;
      ADDR_MATCH_ENABLE = 1'b0;
   end
endmodule // lcdcrs_ctrl

// file: rtl/lcdcrs_frame_div.v
// frame rate divider, clock over two to the fourteenth down to tenth
`timescale 1ns/1ps
`include "lcdcrs_map.vh"
module lcdcrs_frame_div #(
   parameter WIDTH = `LCDCRS_DIV_WIDTH
) (
   input  wire       clk,
   input  wire       sys_rst,
   input  wire       run,
   input  wire [2:0] frame_div_field,
   output reg        frame_tick
);
   // ************************************************************
   // counter
   // ************************************************************
   reg [WIDTH-1:0] count;
   wire [WIDTH-1:0] limit;
   // terminal count is two to (14 - setting) minus one
   assign limit = {WIDTH{1'b1}} >> frame_div_field;
   always @(posedge clk) begin
      if (sys_rst) begin
         count      <= {WIDTH{1'b0}};
         frame_tick <= 1'b0;
      end else if (!run) begin
         frame_tick <= 1'b0;
      end else if (count >= limit) begin
         count      <= {WIDTH{1'b0}};
         frame_tick <= 1'b1;
      end else begin
         count      <= count + {{(WIDTH-1){1'b0}}, 1'b1};
         frame_tick <= 1'b0;
      end
   end
endmodule // lcdcrs_frame_div

// file: rtl/lcdcrs_map.vh
// constants for the reset, standby and command decode block
`ifndef LCDCRS_MAP_VH
`define LCDCRS_MAP_VH
// ************************************************************
// command codes
// ************************************************************
`define LCDCRS_CMD_STOP        8'h01
`define LCDCRS_CMD_DISPLAY_OFF_CMD    8'h08
`define LCDCRS_CMD_DISPLAY_ON_CMD     8'h09
`define LCDCRS_CMD_FRAME_LO    8'h10
`define LCDCRS_CMD_FRAME_HI    8'h14
`define LCDCRS_CMD_MUX_LO      8'h18
`define LCDCRS_CMD_MUX_HI      8'h1f
`define LCDCRS_CMD_BCLR_LO     8'h20
`define LCDCRS_CMD_BCLR_HI     8'h3f
`define LCDCRS_CMD_BIT_SET_CMD_LO     8'h40
`define LCDCRS_CMD_BIT_SET_CMD_HI     8'h5f
`define LCDCRS_CMD_READ_LO     8'h60
`define LCDCRS_CMD_READ_HI     8'h63
`define LCDCRS_CMD_WRITE_LO    8'h64
`define LCDCRS_CMD_WRITE_HI    8'h67
`define LCDCRS_CMD_OR_LO       8'h68
`define LCDCRS_CMD_OR_HI       8'h6b
`define LCDCRS_CMD_AND_LO      8'h6c
`define LCDCRS_CMD_AND_HI      8'h6f
`define LCDCRS_CMD_CHAR_LEFT   8'h71
`define LCDCRS_CMD_CHAR_RIGHT  8'h72
`define LCDCRS_CMD_CUR_CLR     8'h7c
`define LCDCRS_CMD_CUR_WR      8'h7d
`define LCDCRS_CMD_PTR_A_LO    8'h80
`define LCDCRS_CMD_PTR_A_HI    8'hb1
`define LCDCRS_CMD_PTR_B_LO    8'hc0
`define LCDCRS_CMD_PTR_B_HI    8'hf1
// ************************************************************
// processing modes
// ************************************************************
`define LCDCRS_MODE_WRITE      3'h0
`define LCDCRS_MODE_READ       3'h1
`define LCDCRS_MODE_OR         3'h2
`define LCDCRS_MODE_AND        3'h3
`define LCDCRS_MODE_CHAR_LEFT  3'h4
`define LCDCRS_MODE_CHAR_RIGHT 3'h5
// ************************************************************
// reset values and frame divider constants
// ************************************************************
`define LCDCRS_RST_ADDR        2'h0
`define LCDCRS_RST_STEP        2'h0
`define LCDCRS_RST_PTR         7'h00
`define LCDCRS_RST_MUX         3'h0
`define LCDCRS_RST_FRAME       3'h0
`define LCDCRS_FRAME_MAX       3'h4
`define LCDCRS_DIV_BASE_EXP    14
`define LCDCRS_DIV_WIDTH       14
// ************************************************************
// drive levels
// ************************************************************
`define LCDCRS_DRIVE_MID_BIAS  2'h0
`define LCDCRS_DRIVE_OFF       2'h1
`define LCDCRS_DRIVE_ON        2'h2
`endif

// file: verification/lcdcrs_ctrl_monitor.sv
// concurrent checks on the ports of the reset, standby and command decode block
`timescale 1ns/1ps
module lcdcrs_ctrl_monitor (
   input logic       CLK,
   input logic       SYS_RST,
   input logic       CMD_VALID,
   input logic [7:0] CMD_BYTE,
   input logic       STRAP_ADDR_BIT0,
   input logic       STRAP_ADDR_BIT1,
   input logic       PAR_SER_PIN,
   input logic       ADDR_MATCH_ENABLE_STRAP,
   input logic       READY_N_OUT,
   input logic       READY_N_OE,
   input logic       STANDBY,
   input logic       CLOCK_RUN,
   input logic [1:0] DRIVE_LEVEL,
   input logic       DISPLAY_ON,
   input logic [2:0] PROC_MODE,
   input logic [6:0] POINTER,
   input logic [2:0] MULTIPLEX_FIELD,
   input logic [2:0] FRAME_DIV_FIELD,
   input logic       PARALLEL_MODE,
   input logic       ADDR_MATCH_ENABLE,
   input logic [1:0] CHIP_ADDR_CMP,
   input logic       CHIP_SELECTED
);
   default clocking cb @(posedge CLK); endclocking
   wire cmd = CMD_VALID & ~SYS_RST;
   // ************************************************************
   // reset and standby
   // ************************************************************
   a_stop_enters_standby: assert property (disable iff (SYS_RST) cmd && CMD_BYTE == 8'h01 |=> STANDBY && READY_N_OUT && !CLOCK_RUN) else $error("stop did not enter standby");
   a_reset_mid_bias: assert property (SYS_RST |=> DRIVE_LEVEL == 2'h0 && !CLOCK_RUN && CHIP_ADDR_CMP == 2'h0) else $error("reset drive state wrong");
   a_reset_fields_zero: assert property (SYS_RST |=> PROC_MODE == 3'h0 && POINTER == 7'h00 && MULTIPLEX_FIELD == 3'h0 && FRAME_DIV_FIELD == 3'h0) else $error("reset fields wrong");
   a_standby_kept: assert property (SYS_RST && STANDBY |=> STANDBY) else $error("standby lost in reset");
   a_ready_in_reset: assert property (SYS_RST[*4] |-> !READY_N_OE || ({STRAP_ADDR_BIT1, STRAP_ADDR_BIT0} == 2'h0 && !READY_N_OUT)) else $error("ready pin wrong in reset");
   a_release_state: assert property ($fell(SYS_RST) |=> !STANDBY && !DISPLAY_ON && DRIVE_LEVEL == 2'h1) else $error("state after release wrong");
   a_strap_latch: assert property ($fell(SYS_RST) |=> PARALLEL_MODE == $past(PAR_SER_PIN) && ADDR_MATCH_ENABLE == $past(ADDR_MATCH_ENABLE_STRAP) && CHIP_SELECTED == ({STRAP_ADDR_BIT1, STRAP_ADDR_BIT0} == 2'h0)) else $error("straps not latched");
   // ************************************************************
   // command decode
   // ************************************************************
   a_frame_cmd_load: assert property (disable iff (SYS_RST) cmd && CMD_BYTE inside {[8'h10:8'h14]} |=> FRAME_DIV_FIELD == $past(CMD_BYTE[2:0])) else $error("frame setting not loaded");
   a_ptr_cmd_load: assert property (disable iff (SYS_RST) cmd && CMD_BYTE inside {[8'h80:8'hb1], [8'hc0:8'hf1]} |=> POINTER == $past(CMD_BYTE[6:0])) else $error("pointer not loaded");
   a_read_mode_set: assert property (disable iff (SYS_RST) cmd && CMD_BYTE inside {[8'h60:8'h63]} |=> PROC_MODE == 3'h1) else $error("read mode not set");
   a_unlisted_quiet: assert property (disable iff (SYS_RST) cmd && CMD_BYTE inside {8'h00, 8'h15, 8'h70, 8'hb2, 8'hf2} |=> $stable(POINTER) && $stable(PROC_MODE) && $stable(MULTIPLEX_FIELD) && $stable(FRAME_DIV_FIELD)) else $error("unlisted code changed state");
endmodule // lcdcrs_ctrl_monitor
bind lcdcrs_ctrl lcdcrs_ctrl_monitor u_lcdcrs_ctrl_monitor (.*);

// file: verification/lcdcrs_ctrl_tb.sv
// self-checking bench for the reset, standby and command decode block
`timescale 1ns/1ps
module lcdcrs_ctrl_tb;
   logic       CLK = 1'b0;
   logic       SYS_RST, CS_N, STRAP_ADDR_BIT0, STRAP_ADDR_BIT1, PAR_SER_PIN, ADDR_MATCH_ENABLE_STRAP;
   logic       CMD_VALID, DATA_VALID, BYTE_PART, READY_N_OUT, READY_N_OE, STANDBY, CLOCK_RUN, DISPLAY_ON;
   logic       MEM_HOLD, FRAME_TICK, PARALLEL_MODE, ADDR_MATCH_ENABLE, CHIP_SELECTED, XFER_PART;
   logic       BIT_CLEAR_CMD, BIT_SET_CMD, CURSOR_CLEAR_CMD, CURSOR_WRITE_CMD;
   logic [7:0] CMD_BYTE;
   logic [1:0] DRIVE_LEVEL, POINTER_STEP_FIELD, CHIP_ADDR_CMP;
   logic [2:0] PROC_MODE, MULTIPLEX_FIELD, FRAME_DIV_FIELD;
   logic [4:0] BIT_OPERAND;
   logic [6:0] POINTER;
   int         n_mismatch = 0;
   int         checked = 0;
   lcdcrs_ctrl u_lcdcrs_ctrl (.*);
   lcdcrs_host u_lcdcrs_host (.*);
   always #2.5 CLK = ~CLK;
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tick(output int n);
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (FRAME_TICK !== 1'b1 && n < 40000);
   endtask
   initial begin
      #450000;
      n_mismatch++;
      summarize();
   end
   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      logic [7:0]  md [6] = '{8'h61, 8'h66, 8'h6b, 8'h6c, 8'h71, 8'h72};
      logic [2:0]  em [6] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
      logic [7:0]  fc [10] = '{8'hb1, 8'hc0, 8'hf1, 8'hb2, 8'h1f, 8'h1a, 8'h14, 8'h15, 8'h09, 8'h00};
      logic [13:0] fe [10] = '{14'h1880, 14'h2000, 14'h3880, 14'h3880, 14'h38f0, 14'h38a0, 14'h38a8, 14'h38a8, 14'h38a9, 14'h38a9};
      logic [7:0]  pc [4] = '{8'h3f, 8'h40, 8'h7c, 8'h7d};
      int          n;
      repeat (10) @(negedge CLK);
      chk("reset_pins", {READY_N_OE, READY_N_OUT, DRIVE_LEVEL, CHIP_ADDR_CMP}, 6'h20);
      u_lcdcrs_host.rst_lo();
      @(negedge CLK);
      chk("release", {PARALLEL_MODE, ADDR_MATCH_ENABLE, CHIP_SELECTED, DISPLAY_ON, DRIVE_LEVEL}, 6'h29);
      chk("fields", {PROC_MODE, POINTER_STEP_FIELD, POINTER, MULTIPLEX_FIELD, FRAME_DIV_FIELD}, 16'h0);
      for (int i = 0; i < 6; i++) begin
         u_lcdcrs_host.send(md[i]);
         chk("mode", {PROC_MODE, (i < 4) ? POINTER_STEP_FIELD : md[i][1:0]}, {em[i], md[i][1:0]});
      end
      for (int i = 0; i < 10; i++) begin
         u_lcdcrs_host.send(fc[i]);
         chk("decode", {POINTER, MULTIPLEX_FIELD, FRAME_DIV_FIELD, DISPLAY_ON}, fe[i]);
      end
      u_lcdcrs_host.send(8'h08);
      chk("display_off_cmd", DISPLAY_ON, 1'b0);
      for (int i = 0; i < 4; i++) begin
         u_lcdcrs_host.send(pc[i]);
         chk("pulse", {BIT_CLEAR_CMD, BIT_SET_CMD, CURSOR_CLEAR_CMD, CURSOR_WRITE_CMD}, 4'h8 >> i);
         if (i < 2) chk("operand", BIT_OPERAND, pc[i][4:0]);
      end
      for (int i = 0; i < 5; i++) begin
         u_lcdcrs_host.send(8'h10 + 8'(i));
         tick(n);
         tick(n);
         chk("frame_period", 16'(n), 16'h4000 >> i);
      end
      u_lcdcrs_host.send(8'h6b);
      u_lcdcrs_host.send(8'h01);
      chk("standby", {STANDBY, READY_N_OUT, CLOCK_RUN}, 3'h6);
      u_lcdcrs_host.rst_hi(1'b1);
      repeat (4) @(negedge CLK);
      chk("sb_reset", {STANDBY, DRIVE_LEVEL, MEM_HOLD, PROC_MODE, POINTER_STEP_FIELD}, 9'h120);
      u_lcdcrs_host.rst_lo();
      @(negedge CLK);
      chk("woken", {STANDBY, MEM_HOLD, CLOCK_RUN}, 3'h3);
      u_lcdcrs_host.send(8'h01);
      chk("standby2", {STANDBY, READY_N_OUT, CLOCK_RUN}, 3'h6);
      u_lcdcrs_host.data();
      chk("byte_wake", {STANDBY, CLOCK_RUN}, 2'h1);
      u_lcdcrs_host.pins(6'h25);
      repeat (5) @(negedge CLK);
      u_lcdcrs_host.rst_hi(1'b0);
      u_lcdcrs_host.send(8'h09);
      repeat (5) @(negedge CLK);
      chk("other_addr", {READY_N_OE, DISPLAY_ON, XFER_PART, CHIP_ADDR_CMP}, 5'h0);
      u_lcdcrs_host.rst_lo();
      @(negedge CLK);
      chk("straps", {PARALLEL_MODE, ADDR_MATCH_ENABLE, CHIP_SELECTED}, 3'h2);
      u_lcdcrs_host.pins(6'h12);
      repeat (5) @(negedge CLK);
      u_lcdcrs_host.rst_hi(1'b0);
      repeat (5) @(negedge CLK);
      chk("cs_high", READY_N_OE, 1'b0);
      u_lcdcrs_host.pins(6'h02);
      repeat (5) @(negedge CLK);
      chk("cs_low", {READY_N_OE, READY_N_OUT}, 2'h2);
      u_lcdcrs_host.rst_lo();
      repeat (2) @(negedge CLK);
      summarize();
   end
endmodule // lcdcrs_ctrl_tb

// file: verification/lcdcrs_host.sv
// host processor model driving reset, select, straps and command bytes
`timescale 1ns/1ps
module lcdcrs_host (
   input  logic       CLK,
   input  logic       READY_N_OUT,
   input  logic       READY_N_OE,
   output logic       SYS_RST,
   output logic       CS_N,
   output logic       STRAP_ADDR_BIT0,
   output logic       STRAP_ADDR_BIT1,
   output logic       PAR_SER_PIN,
   output logic       ADDR_MATCH_ENABLE_STRAP,
   output logic       CMD_VALID,
   output logic [7:0] CMD_BYTE,
   output logic       DATA_VALID,
   output logic       BYTE_PART
);
   // busy pin with pull-up when released
   wire ready_pin = READY_N_OE ? READY_N_OUT : 1'b1;
   initial begin
      {SYS_RST, CMD_VALID, CMD_BYTE, DATA_VALID} = {1'b1, 1'b0, 8'h5a, 1'b0};
      {BYTE_PART, CS_N, STRAP_ADDR_BIT1, STRAP_ADDR_BIT0, PAR_SER_PIN, ADDR_MATCH_ENABLE_STRAP} = 6'h02;
   end
   task automatic send(input logic [7:0] b);
      @(negedge CLK);
      CMD_VALID = 1'b1;
      CMD_BYTE = b;
      @(negedge CLK);
      CMD_VALID = 1'b0;
      CMD_BYTE = ~b;
   endtask
   // in standby, reset once ready reads high or after 100 cycles of waiting
   task automatic rst_hi(input logic sb);
      int n = 0;
      @(negedge CLK);
      while (sb && ready_pin !== 1'b1 && n < 100) begin
         @(negedge CLK);
         n++;
      end
      SYS_RST = 1'b1;
   endtask
   task automatic data();
      @(negedge CLK);
      DATA_VALID = 1'b1;
      @(negedge CLK);
      DATA_VALID = 1'b0;
   endtask
   task automatic rst_lo();
      @(negedge CLK);
      SYS_RST = 1'b0;
   endtask
   task automatic pins(input logic [5:0] v);
      @(negedge CLK);
      {BYTE_PART, CS_N, STRAP_ADDR_BIT1, STRAP_ADDR_BIT0, PAR_SER_PIN, ADDR_MATCH_ENABLE_STRAP} = v;
   endtask
endmodule // lcdcrs_host
